/* File: common/dual_irq_defs.vh */
// constants for the dual master interrupt logic
`ifndef DUAL_IRQ_DEFS_VH
`define DUAL_IRQ_DEFS_VH

// status register pointer value (low two pointer bits)
`define STAT_PTR        2'b10

// status register bit positions
`define BIT_PEER_TEST   7
`define BIT_SELF_TEST   6
`define BIT_UNUSED_HI   5
`define BIT_UNUSED_LO   4
`define BIT_LOST_CTRL   3
`define BIT_NOT_IDLE    2
`define BIT_REC_DONE    1
`define BIT_DS_IRQ      0

// reset values
`define STAT_RST        8'h00
`define FLAG_RST        1'b0
`define BUSY_RST        1'b0
`define CNT_RST         2'h0

// read clear happens on this scl rising edge of a status read
`define CLR_EDGE_IDX    2'h1
`define CNT_MAX         2'h3

// channel count and synchroniser layout
`define NUM_CH          2
`define SYNC_W          5
`define SY_SCL0         0
`define SY_SCL1         1
`define SY_DS_SCL       2
`define SY_DS_SDA       3
`define SY_DS_IRQ_N     4

`endif

/* File: hdl/sync2.v */
// two flip-flop synchroniser for a group of independent level signals
`timescale 1ns/1ps
module sync2 #(
   parameter WIDTH = 1
) (
   input  wire             sys_clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] async_in,
   input  wire [WIDTH-1:0] rst_val,
   output wire [WIDTH-1:0] sync_out
);

   genvar b;
   generate
      for (b = 0; b < WIDTH; b = b + 1)
      begin : g_bit
         reg meta_q;
         reg sync_q;
         // rst_val is a constant at every instance, keeps idle-high pins quiet
         always @(posedge sys_clk)
         begin
            if (reset)
            begin
               meta_q <= rst_val[b];
               sync_q <= rst_val[b];
            end
            else
            begin
               meta_q <= async_in[b];
               sync_q <= meta_q;
            end
         end
         assign sync_out[b] = sync_q;
      end
   endgenerate

endmodule // sync2

/* File: hdl/dual_master_interrupt_logic.v */
// interrupt logic of a two master bus selector: flags, masks, status, irq pins
// Functional notes
// - losing master gets irq after disconnection
// - lost control mask suppresses that irq
// - recovery request makes recovery precede connection
// - recovery completion raises new master irq
// - recovery done mask suppresses completion irq
// - no recovery: busy bus at switch raises irq
// - not idle mask suppresses bus sensor irq
// - low downstream input drives both irqs low
// - downstream mask blocks only own channel
// - self test bit drives own irq low
// - peer test bit drives other irq low
// - clearing test bits removes test irqs
// - irq outputs are open drain, pull low only
// - two status copies, reader gets own copy
// - status at pointer 10b, bits 5:4 zero
// - bit 7 mirrors peer test request
// - bit 6 mirrors own self test request
// - bit 3 set on lost control event
// - bit 2 set on busy switch without recovery
// - bit 1 set on recovery completion
// - bit 0 follows downstream interrupt input
// - status read clears bits 3:1 on second scl
// - read leaves test and downstream bits alone
// - downstream still low after read re-raises irq
`timescale 1ns/1ps
`include "dual_irq_defs.vh"
module dual_master_interrupt_logic (
   input  wire       sys_clk,
   input  wire       reset,
   // ****************************************************************
   // upstream master ports (scl pins, slave engine read qualifiers)
   // ****************************************************************
   input  wire       scl_ch0,
   input  wire       scl_ch1,
   input  wire       rd_active_ch0,
   input  wire       rd_active_ch1,
   input  wire [1:0] reg_ptr_ch0,
   input  wire [1:0] reg_ptr_ch1,
   // ****************************************************************
   // control register bits, one per channel, index = channel
   // ****************************************************************
   input  wire [1:0] lost_ctrl_mask,
   input  wire [1:0] recovery_done_mask,
   input  wire [1:0] not_idle_mask,
   input  wire [1:0] downstream_irq_mask,
   input  wire [1:0] self_test_req,
   input  wire [1:0] peer_test_req,
   input  wire [1:0] recovery_request,
   // ****************************************************************
   // switch sequencer events
   // ****************************************************************
   input  wire       lost_ev,
   input  wire       lost_ch,
   input  wire       connect_ev,
   input  wire       connect_ch,
   input  wire       rec_done_ev,
   // ****************************************************************
   // downstream pins
   // ****************************************************************
   input  wire       ds_scl,
   input  wire       ds_sda,
   input  wire       ds_irq_n,
   // ****************************************************************
   // outputs
   // ****************************************************************
   output wire       irq_out_ch0_o,
   output wire       irq_out_ch0_oe_n,
   output wire       irq_out_ch1_o,
   output wire       irq_out_ch1_oe_n,
   output wire [7:0] status_ch0,
   output wire [7:0] status_ch1,
   output wire       ds_busy
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   wire [`SYNC_W-1:0] pins_raw;
   wire [`SYNC_W-1:0] pins_s;

   assign pins_raw = {ds_irq_n, ds_sda, ds_scl, scl_ch1, scl_ch0};

   // idle bus and released irq input are high, so reset to ones
   sync2 #(
      .WIDTH (`SYNC_W)
   ) u_sync (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in (pins_raw),
      .rst_val  ({`SYNC_W{1'b1}}),
      .sync_out (pins_s)
   );

   wire ds_irq_act;

   assign ds_irq_act = ~pins_s[`SY_DS_IRQ_N];

   // ****************************************************************
   // downstream bus sensor: start/stop watcher
   // ****************************************************************
   reg ds_scl_q;
   reg ds_sda_q;
   reg busy_q;
   reg busy_d;

   always @*
   begin
      busy_d = busy_q;
      if (ds_scl_q && pins_s[`SY_DS_SCL])
      begin
         if (ds_sda_q && !pins_s[`SY_DS_SDA])
            busy_d = 1'b1;
         else if (!ds_sda_q && pins_s[`SY_DS_SDA])
            busy_d = 1'b0;
      end
   end

   // sensor runs all the time, recovery or not
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         ds_scl_q <= 1'b1;
         ds_sda_q <= 1'b1;
         busy_q   <= `BUSY_RST;
      end
      else
      begin
         ds_scl_q <= pins_s[`SY_DS_SCL];
         ds_sda_q <= pins_s[`SY_DS_SDA];
         busy_q   <= busy_d;
      end
   end

   assign ds_busy = busy_q;

   // ****************************************************************
   // per channel flags, status copy and irq pin
   // ****************************************************************
   wire [1:0] scl_s;
   wire [1:0] rd_act;
   wire [3:0] ptr_all;
   wire [7:0] stat_w [0:1];
   wire [1:0] oe_n_w;

   assign scl_s   = {pins_s[`SY_SCL1], pins_s[`SY_SCL0]};
   assign rd_act  = {rd_active_ch1, rd_active_ch0};
   assign ptr_all = {reg_ptr_ch1, reg_ptr_ch0};

   genvar i;
   generate
      for (i = 0; i < `NUM_CH; i = i + 1)
      begin : g_ch
         reg        scl_q;
         reg [1:0]  edge_cnt_q;
         reg [1:0]  edge_cnt_d;
         reg        lost_q;
         reg        rdone_q;
         reg        nidle_q;
         reg [7:0]  stat_q;
         reg [7:0]  stat_d;
         reg        oe_n_q;
         wire       scl_rise;
         wire       stat_sel;
         wire       rd_clr;
         wire       set_lost;
         wire       set_rdone;
         wire       set_nidle;
         wire       peer_test;
         wire       pend;

         // ----- read clear timing -----
         assign scl_rise = scl_s[i] && !scl_q;
         assign stat_sel = rd_act[i] && (ptr_all[2*i+1:2*i] == `STAT_PTR);
         // second rising scl edge while reading own status
         assign rd_clr   = stat_sel && scl_rise && (edge_cnt_q == `CLR_EDGE_IDX);

         always @*
         begin
            edge_cnt_d = edge_cnt_q;
            if (!rd_act[i])
               edge_cnt_d = `CNT_RST;
            else if (scl_rise && edge_cnt_q != `CNT_MAX)
               edge_cnt_d = edge_cnt_q + 2'h1;
         end

         // ----- event sources -----
         assign set_lost  = lost_ev && (lost_ch == i);
         // recovery done is only reported when this master asked for it
         assign set_rdone = rec_done_ev && (connect_ch == i)
                            && recovery_request[i];
         // bus sensor only counts when recovery was not requested
         assign set_nidle = connect_ev && (connect_ch == i)
                            && !recovery_request[i] && busy_q;
         assign peer_test = peer_test_req[1-i];

         // ----- status byte -----
         always @*
         begin
            stat_d = `STAT_RST;
            stat_d[`BIT_PEER_TEST] = peer_test;
            stat_d[`BIT_SELF_TEST] = self_test_req[i];
            stat_d[`BIT_UNUSED_HI] = 1'b0;
            stat_d[`BIT_UNUSED_LO] = 1'b0;
            stat_d[`BIT_LOST_CTRL] = lost_q;
            stat_d[`BIT_NOT_IDLE]  = nidle_q;
            stat_d[`BIT_REC_DONE]  = rdone_q;
            // level, never cleared by a read
            stat_d[`BIT_DS_IRQ]    = ds_irq_act;
         end

         // ----- irq pending, mask per flag source, test bits never masked -----
         assign pend = (lost_q  && !lost_ctrl_mask[i])
                    || (rdone_q && !recovery_done_mask[i])
                    || (nidle_q && !not_idle_mask[i])
                    || (ds_irq_act && !downstream_irq_mask[i])
                    || self_test_req[i]
                    || peer_test;

         always @(posedge sys_clk)
         begin
            if (reset)
            begin
               scl_q      <= 1'b1;
               edge_cnt_q <= `CNT_RST;
               lost_q     <= `FLAG_RST;
               rdone_q    <= `FLAG_RST;
               nidle_q    <= `FLAG_RST;
               stat_q     <= `STAT_RST;
               oe_n_q     <= 1'b1;
            end
            else
            begin
               scl_q      <= scl_s[i];
               edge_cnt_q <= edge_cnt_d;
               // a new event in the clearing cycle wins over the clear
               if (set_lost)
                  lost_q <= 1'b1;
               else if (rd_clr)
                  lost_q <= 1'b0;
               if (set_rdone)
                  rdone_q <= 1'b1;
               else if (rd_clr)
                  rdone_q <= 1'b0;
               if (set_nidle)
                  nidle_q <= 1'b1;
               else if (rd_clr)
                  nidle_q <= 1'b0;
               stat_q     <= stat_d;
               // enable low only while asserting, else released
               oe_n_q     <= ~pend;
            end
         end

         assign stat_w[i] = stat_q;
         assign oe_n_w[i] = oe_n_q;
      end
   endgenerate

   // ****************************************************************
   // output pins
   // ****************************************************************
   // data side of the open-drain pins is held low from a flop
   reg drive_lvl_q;

   always @(posedge sys_clk)
   begin
      if (reset)
         drive_lvl_q <= 1'b0;
      else
         drive_lvl_q <= 1'b0;
   end

   assign irq_out_ch0_o    = drive_lvl_q;
   assign irq_out_ch1_o    = drive_lvl_q;
   assign irq_out_ch0_oe_n = oe_n_w[0];
   assign irq_out_ch1_oe_n = oe_n_w[1];
   assign status_ch0       = stat_w[0];
   assign status_ch1       = stat_w[1];

endmodule // dual_master_interrupt_logic

/* File: dv/dual_irq_asserts.sv */
// port checker for the dual master interrupt logic
`timescale 1ns/1ps
module dual_irq_asserts (
   input wire       sys_clk,
   input wire       reset,
   input wire       lost_ev,
   input wire       lost_ch,
   input wire       rec_done_ev,
   input wire       connect_ch,
   input wire [1:0] lost_ctrl_mask,
   input wire [1:0] recovery_request,
   input wire [1:0] self_test_req,
   input wire [1:0] peer_test_req,
   input wire       irq_out_ch0_o,
   input wire       irq_out_ch1_o,
   input wire       irq_out_ch0_oe_n,
   input wire       irq_out_ch1_oe_n,
   input wire [7:0] status_ch0,
   input wire [7:0] status_ch1
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ***
   // event steps
   // ***
   sequence s_lost1;
      lost_ev && lost_ch && !lost_ctrl_mask[1];
   endsequence
   sequence s_lost_seen;
      status_ch1[3] && !irq_out_ch1_oe_n;
   endsequence
   sequence s_rec0;
      rec_done_ev && !connect_ch && recovery_request[0];
   endsequence
   // mirrors look one edge back, so skip the edges right after reset
   sequence s_settled;
      !$past(reset) && !$past(reset, 2);
   endsequence
   a_lost_raise: assert property (s_lost1 |-> ##2 s_lost_seen)
      else $error("lost control not flagged");
   a_rec_flag: assert property (s_rec0 |-> ##2 status_ch0[1])
      else $error("recovery done not flagged");
   a_unused_zero: assert property (status_ch0[5:4] == 2'h0 && status_ch1[5:4] == 2'h0)
      else $error("unused bits set");
   a_drain_only: assert property (!irq_out_ch0_o && !irq_out_ch1_o)
      else $error("irq data not low");
   a_self_mirror: assert property (s_settled |-> status_ch0[6] == $past(self_test_req[0]))
      else $error("self test bit wrong");
   a_peer_mirror: assert property (s_settled |-> status_ch1[7] == $past(peer_test_req[0]))
      else $error("peer test bit wrong");
   a_test_irq: assert property (status_ch0[6] && $past(status_ch0[6]) |-> !irq_out_ch0_oe_n)
      else $error("self test irq missing");
   a_idle_release: assert property (status_ch0 == 8'h00 && $past(status_ch0) == 8'h00
      |-> irq_out_ch0_oe_n)
      else $error("irq held without cause");
endmodule // dual_irq_asserts
bind dual_master_interrupt_logic dual_irq_asserts dual_irq_asserts_i (
   .sys_clk(sys_clk), .reset(reset), .lost_ev(lost_ev), .lost_ch(lost_ch),
   .rec_done_ev(rec_done_ev), .connect_ch(connect_ch), .lost_ctrl_mask(lost_ctrl_mask),
   .recovery_request(recovery_request), .self_test_req(self_test_req),
   .peer_test_req(peer_test_req), .irq_out_ch0_o(irq_out_ch0_o), .irq_out_ch1_o(irq_out_ch1_o),
   .irq_out_ch0_oe_n(irq_out_ch0_oe_n), .irq_out_ch1_oe_n(irq_out_ch1_oe_n),
   .status_ch0(status_ch0), .status_ch1(status_ch1));

/* File: dv/upstream_masters_model.sv */
// two upstream masters reading the status register
`timescale 1ns/1ps
module upstream_masters_model (
   input  wire       sys_clk,
   input  wire       start,
   input  wire       ch,
   output reg        scl_ch0 = 1'b1,
   output reg        scl_ch1 = 1'b1,
   output reg        rd_active_ch0 = 1'b0,
   output reg        rd_active_ch1 = 1'b0,
   output reg  [1:0] reg_ptr_ch0 = 2'h1,
   output reg  [1:0] reg_ptr_ch1 = 2'h1,
   output reg        done = 1'b0
);
   integer i;
   // scl stands high outside a read; one byte of 9 pulses per read
   always @(posedge start)
   begin
      done = 1'b0;
      @(posedge sys_clk);
      rd_active_ch0 <= !ch;
      rd_active_ch1 <= ch;
      reg_ptr_ch0 <= ch ? 2'h1 : 2'h2;
      reg_ptr_ch1 <= ch ? 2'h2 : 2'h1;
      for (i = 0; i < 9; i = i + 1)
      begin
         #200 {scl_ch1, scl_ch0} = ch ? 2'h1 : 2'h2;
         #200 {scl_ch1, scl_ch0} = 2'h3;
      end
      @(posedge sys_clk);
      rd_active_ch0 <= 1'b0;
      rd_active_ch1 <= 1'b0;
      reg_ptr_ch0 <= 2'h1;
      reg_ptr_ch1 <= 2'h1;
      done <= 1'b1;
   end
endmodule // upstream_masters_model

/* File: dv/tb_top.sv */
// bench for the dual master interrupt logic
`timescale 1ns/1ps
module tb_top;
   reg        sys_clk = 1'b0;
   reg        reset = 1'b1;
   reg  [1:0] lost_ctrl_mask = 2'h0, recovery_done_mask = 2'h0, not_idle_mask = 2'h0;
   reg  [1:0] downstream_irq_mask = 2'h0, self_test_req = 2'h0, peer_test_req = 2'h0;
   reg  [1:0] recovery_request = 2'h0;
   reg        lost_ev = 1'b0, lost_ch = 1'b0, connect_ev = 1'b0, connect_ch = 1'b0;
   reg        rec_done_ev = 1'b0, ds_scl = 1'b1, ds_sda = 1'b1, ds_irq_n = 1'b1;
   reg        start = 1'b0, ch = 1'b0;
   wire       scl_ch0, scl_ch1, rd_active_ch0, rd_active_ch1, done, ds_busy;
   wire       irq_out_ch0_o, irq_out_ch0_oe_n, irq_out_ch1_o, irq_out_ch1_oe_n;
   wire [1:0] reg_ptr_ch0, reg_ptr_ch1;
   wire [7:0] status_ch0, status_ch1;
   integer    num_errors = 0, n_checks = 0;
   always #25 sys_clk = ~sys_clk;
   dual_master_interrupt_logic dual_master_interrupt_logic_i (
      .sys_clk(sys_clk), .reset(reset), .scl_ch0(scl_ch0), .scl_ch1(scl_ch1),
      .rd_active_ch0(rd_active_ch0), .rd_active_ch1(rd_active_ch1),
      .reg_ptr_ch0(reg_ptr_ch0), .reg_ptr_ch1(reg_ptr_ch1), .lost_ctrl_mask(lost_ctrl_mask),
      .recovery_done_mask(recovery_done_mask), .not_idle_mask(not_idle_mask),
      .downstream_irq_mask(downstream_irq_mask), .self_test_req(self_test_req),
      .peer_test_req(peer_test_req), .recovery_request(recovery_request), .lost_ev(lost_ev),
      .lost_ch(lost_ch), .connect_ev(connect_ev), .connect_ch(connect_ch),
      .rec_done_ev(rec_done_ev), .ds_scl(ds_scl), .ds_sda(ds_sda), .ds_irq_n(ds_irq_n),
      .irq_out_ch0_o(irq_out_ch0_o), .irq_out_ch0_oe_n(irq_out_ch0_oe_n),
      .irq_out_ch1_o(irq_out_ch1_o), .irq_out_ch1_oe_n(irq_out_ch1_oe_n),
      .status_ch0(status_ch0), .status_ch1(status_ch1), .ds_busy(ds_busy));
   upstream_masters_model upstream_masters_model_i (
      .sys_clk(sys_clk), .start(start), .ch(ch), .scl_ch0(scl_ch0), .scl_ch1(scl_ch1),
      .rd_active_ch0(rd_active_ch0), .rd_active_ch1(rd_active_ch1),
      .reg_ptr_ch0(reg_ptr_ch0), .reg_ptr_ch1(reg_ptr_ch1), .done(done));
   task close_out;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // wide enough for both status bytes side by side
   task chk(input [15:0] seen, input [15:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("BAD at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task cy(input integer n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task rd(input c);
      integer k;
      @(posedge sys_clk);
      start <= 1'b1;
      ch <= c;
      cy(2);
      for (k = 0; k < 200 && done !== 1'b1; k = k + 1)
         cy(1);
      if (k == 200)
      begin
         num_errors = num_errors + 1;
         close_out;
      end
      @(posedge sys_clk);
      start <= 1'b0;
      cy(4);
   endtask
   // w bits: rec_done_ev, connect_ev, lost_ev
   task ev(input [2:0] w, input c);
      @(posedge sys_clk);
      {rec_done_ev, connect_ev, lost_ev} <= w;
      lost_ch <= c;
      if (w[1])
         connect_ch <= c;
      @(posedge sys_clk);
      {rec_done_ev, connect_ev, lost_ev} <= 3'h0;
      cy(3);
   endtask
   task t_lost;
      ev(3'h1, 1'b1);
      chk(status_ch1, 8'h08);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h01);
      rd(1'b1);
      chk(status_ch1, 8'h00);
      chk(irq_out_ch1_oe_n, 8'h01);
      lost_ctrl_mask <= 2'h1;
      ev(3'h1, 1'b0);
      chk(status_ch0, 8'h08);
      chk(irq_out_ch0_oe_n, 8'h01);
      rd(1'b0);
      $display("lost test done");
   endtask
   task t_rec;
      recovery_request <= 2'h1;
      ev(3'h2, 1'b0);
      ev(3'h4, 1'b0);
      chk(status_ch0, 8'h02);
      chk(irq_out_ch0_oe_n, 8'h00);
      rd(1'b0);
      chk(status_ch0, 8'h00);
      recovery_done_mask <= 2'h1;
      ev(3'h4, 1'b0);
      chk(irq_out_ch0_oe_n, 8'h01);
      rd(1'b0);
      $display("recovery test done");
   endtask
   task t_sense;
      ds_sda <= 1'b0;
      recovery_request <= 2'h2;
      cy(5);
      chk(ds_busy, 8'h01);
      ev(3'h2, 1'b1);
      chk(status_ch1, 8'h00);
      recovery_request <= 2'h0;
      ev(3'h2, 1'b1);
      chk(status_ch1, 8'h04);
      chk(irq_out_ch1_oe_n, 8'h00);
      rd(1'b1);
      not_idle_mask <= 2'h2;
      ev(3'h2, 1'b1);
      chk({status_ch1[2], irq_out_ch1_oe_n}, 8'h03);
      rd(1'b1);
      ds_sda <= 1'b1;
      cy(5);
      ev(3'h2, 1'b1);
      chk({ds_busy, status_ch1}, 8'h00);
      $display("sensor test done");
   endtask
   task t_ds;
      downstream_irq_mask <= 2'h2;
      ds_irq_n <= 1'b0;
      cy(6);
      chk(status_ch0, 8'h01);
      chk(status_ch1, 8'h01);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h02);
      rd(1'b0);
      chk(status_ch0, 8'h01);
      chk(irq_out_ch0_oe_n, 8'h00);
      ds_irq_n <= 1'b1;
      cy(6);
      chk({status_ch1, status_ch0}, 8'h00);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h03);
      $display("downstream test done");
   endtask
   task t_tests;
      self_test_req <= 2'h1;
      peer_test_req <= 2'h1;
      cy(4);
      chk(status_ch0, 8'h40);
      chk(status_ch1, 8'h80);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h00);
      rd(1'b0);
      chk(status_ch0, 8'h40);
      self_test_req <= 2'h0;
      peer_test_req <= 2'h0;
      cy(4);
      chk({status_ch1, status_ch0}, 8'h00);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h03);
      $display("test bits done");
   endtask
   initial
   begin
      cy(8);
      reset <= 1'b0;
      cy(3);
      chk({status_ch1, status_ch0}, 8'h00);
      chk({irq_out_ch1_oe_n, irq_out_ch0_oe_n}, 8'h03);
      t_lost;
      t_rec;
      t_sense;
      t_ds;
      t_tests;
      close_out;
   end
endmodule // tb_top
